// >>> rtl/utric_pkg.sv
// Shared constants of the serial port enable and interrupt control block
package utric_pkg;
  // Register bus widths
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int WORD_W = 9;
  // Register offsets
  localparam logic [2:0] REG_CTRL2 = 3'h0;
  localparam logic [2:0] REG_CTRL1 = 3'h1;
  localparam logic [2:0] REG_BAUD = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_DATA = 3'h4;
  // Reset values
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [8:0] WORD_RESET = 9'h000;
  // Second control register fields
  localparam int C2_TXEN = 7;
  localparam int C2_RXEN = 6;
  localparam int C2_HIGH_SPEED = 5;
  localparam int C2_ADDR_DET = 4;
  localparam int C2_WAKE = 3;
  localparam int C2_RX_IE = 2;
  localparam int C2_TX_IDLE_IE = 1;
  localparam int C2_TX_EMPTY_IE = 0;
  // First control register fields
  localparam int C1_MASTER = 7;
  localparam int C1_WORD_NINE = 6;
  localparam int C1_WAKE_IE = 4;
  // Status register fields
  localparam int ST_OVERRUN = 0;
  localparam int ST_RX_AVAIL = 1;
  localparam int ST_TX_IDLE = 2;
  localparam int ST_TX_EMPTY = 3;
  localparam int ST_ADDR = 4;
  localparam int ST_WAKE = 5;
  localparam int ST_INT = 6;
  localparam int ST_BIT_NINE = 7;
  // Received word bit positions for the address bit
  localparam int ADDR_BIT_8 = 7;
  localparam int ADDR_BIT_9 = 8;
  // Baud prescale terminal counts: divide by 64 or by 16
  localparam int PRESCALE_W = 6;
  localparam logic [5:0] PRESCALE_LOW = 6'h3F;
  localparam logic [5:0] PRESCALE_HIGH = 6'h0F;
  localparam logic [5:0] PRESCALE_ZERO = 6'h00;
  localparam logic [7:0] DIV_ZERO = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
endpackage

// >>> rtl/utric_baud.sv
// Free running baud rate generator: bit tick every prescale*(N+1) clocks
`timescale 1ns/1ps
module utric_baud (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic high_speed,
  input wire logic [7:0] divisor,
  output logic tick
);
  logic [5:0] pre_cnt; // Prescale counter, counts up to the terminal count
  logic [7:0] div_cnt; // Eight bit timer, counts down from N
  wire [5:0] pre_top = high_speed ? utric_pkg::PRESCALE_HIGH : utric_pkg::PRESCALE_LOW;
  wire pre_wrap = (pre_cnt >= pre_top);
  wire div_wrap = pre_wrap && (div_cnt == utric_pkg::DIV_ZERO);
  wire [5:0] next_pre = pre_wrap ? utric_pkg::PRESCALE_ZERO : pre_cnt + 6'h01;

  // Counters restart whenever the port stops, so the first tick comes one prescale period after the start, without the N+1 factor
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      pre_cnt <= utric_pkg::PRESCALE_ZERO;
      div_cnt <= utric_pkg::DIV_ZERO;
      tick <= 1'b0;
    end else begin
      pre_cnt <= next_pre; // RULE5 RULE6
      if (pre_wrap) begin
        div_cnt <= (div_cnt == utric_pkg::DIV_ZERO) ? divisor : div_cnt - 8'h01; // RULE6
      end
      tick <= div_wrap; // RULE6
    end
  end
endmodule

// >>> rtl/utric_ctrl.sv
// Serial port enable, address filter, wake-up and interrupt control block
// How it works
// RULE1: Transmit enable low aborts and floats transmitter
// RULE2: Transmitter runs only with both enables set
// RULE3: Receive enable low aborts and resets receiver
// RULE4: Receiver runs only with both enables set
// RULE5: Speed bit selects high or low baud
// RULE6: Bit rate is clock over 64/16 times N+1
// RULE7: Address words are marked and may interrupt
// RULE8: Address bit is eighth or ninth bit
// RULE9: Non-address words dropped while detect enabled
// RULE10: Word length select gives eight or nine bits
// RULE11: Falling edge with clock off requests wake-up
// RULE12: No wake-up while clock runs or disabled
// RULE13: Software restarts clock after wake-up request
// RULE14: Receive enable gates overrun and data flags
// RULE15: Idle enable gates transmitter idle flag
// RULE16: Empty enable gates transmitter empty flag
// RULE17: Master disable empties buffer and releases pins
// RULE18: Interrupt request ORs all enabled sources
`timescale 1ns/1ps
module utric_ctrl (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic SERIAL_IN_PIN,
  input wire logic PORT_CLOCK_OFF,
  input wire logic TX_LINE,
  input wire logic TX_IDLE_IN,
  input wire logic TX_EMPTY_IN,
  input wire logic RX_WORD_VALID,
  input wire logic [8:0] RX_WORD,
  input wire logic RX_OVERRUN_EVT,
  output logic SERIAL_OUT_PIN,
  output logic SERIAL_OUT_OE,
  output logic RX_PIN_CONTROLLED,
  output logic RX_LINE,
  output logic TX_RUN,
  output logic RX_RUN,
  output logic WORD_NINE,
  output logic BAUD_TICK,
  output logic WAKE_REQUEST,
  output logic INT_REQUEST
);
  // Software visible registers
  logic [7:0] uart_tx_rx_int_control; // Second control register
  logic [7:0] ctrl1; // Master enable, word length, wake interrupt enable
  logic [7:0] baud_divisor_register; // Divisor N
  // Received word holding buffer and its flags
  logic [8:0] rx_hold; // Last accepted word
  logic receive_available_flag; // Accepted word waiting to be read
  logic overrun_flag; // Word lost while buffer was full
  logic addr_flag; // Accepted word was an address
  logic wake_flag; // Wake-up request pending
  // Input synchroniser for the receive pin
  logic sync_a; // First stage, read only by the second stage
  logic sync_b; // Second stage
  logic sync_c; // Third stage
  logic rx_level; // Debounced receive level

  // Field views of the control registers
  wire transmit_enable_bit = uart_tx_rx_int_control[utric_pkg::C2_TXEN];
  wire receive_enable_bit = uart_tx_rx_int_control[utric_pkg::C2_RXEN];
  wire baud_speed_select = uart_tx_rx_int_control[utric_pkg::C2_HIGH_SPEED];
  wire address_detect_enable = uart_tx_rx_int_control[utric_pkg::C2_ADDR_DET];
  wire receive_wake_enable = uart_tx_rx_int_control[utric_pkg::C2_WAKE];
  wire receive_interrupt_enable = uart_tx_rx_int_control[utric_pkg::C2_RX_IE];
  wire transmit_idle_interrupt_enable = uart_tx_rx_int_control[utric_pkg::C2_TX_IDLE_IE];
  wire transmit_empty_interrupt_enable = uart_tx_rx_int_control[utric_pkg::C2_TX_EMPTY_IE];
  wire port_master_enable = ctrl1[utric_pkg::C1_MASTER];
  wire word_length_select = ctrl1[utric_pkg::C1_WORD_NINE];
  wire wake_interrupt_enable = ctrl1[utric_pkg::C1_WAKE_IE];

  // Transmitter and receiver run only with their own and the master enable
  wire tx_run = port_master_enable && transmit_enable_bit; // RULE1 RULE2
  wire rx_run = port_master_enable && receive_enable_bit; // RULE3 RULE4

  // Address decode of the register port
  wire hit_ctrl2 = (ADDR == utric_pkg::REG_CTRL2);
  wire hit_ctrl1 = (ADDR == utric_pkg::REG_CTRL1);
  wire hit_baud = (ADDR == utric_pkg::REG_BAUD);
  wire hit_status = (ADDR == utric_pkg::REG_STATUS);
  wire hit_data = (ADDR == utric_pkg::REG_DATA);
  wire wr_ctrl2 = WR && hit_ctrl2;
  wire wr_ctrl1 = WR && hit_ctrl1;
  wire wr_baud = WR && hit_baud;
  wire wr_status = WR && hit_status;
  wire rd_data = RD && hit_data;

  // Address bit position follows the word length
  wire received_bit_eight = RX_WORD[utric_pkg::ADDR_BIT_8];
  wire received_bit_nine = RX_WORD[utric_pkg::ADDR_BIT_9];
  wire addr_bit = word_length_select ? received_bit_nine : received_bit_eight; // RULE8 RULE10
  // With detection on, only address words pass the filter
  wire word_accept = RX_WORD_VALID && rx_run && (!address_detect_enable || addr_bit); // RULE9
  wire word_is_addr = address_detect_enable && addr_bit; // RULE7
  // Ninth bit only exists in nine bit mode
  wire [8:0] word_masked = word_length_select ? RX_WORD :
                           {1'b0, RX_WORD[utric_pkg::ADDR_BIT_9 - 1:0]}; // RULE10

  // Overrun: a new word arrives while the previous one is still unread
  wire buffer_busy = receive_available_flag && !rd_data;
  wire overrun_evt = rx_run && (RX_OVERRUN_EVT || (word_accept && buffer_busy));

  // Receive pin falling edge, taken once the last two stages agree
  wire levels_agree = (sync_b == sync_c);
  wire rx_fall = levels_agree && rx_level && !sync_c;
  // Wake-up only with the wake bit set and the port clock stopped
  wire wake_evt = rx_fall && receive_wake_enable && PORT_CLOCK_OFF; // RULE11 RULE12

  // Transmitter flags read as set while the transmitter is held in reset
  wire transmitter_idle_flag = !tx_run || TX_IDLE_IN; // RULE17
  wire transmitter_empty_flag = !tx_run || TX_EMPTY_IN; // RULE17

  // Next values of the receive flags: set wins over clear
  wire next_avail = word_accept ? 1'b1 : (rd_data ? 1'b0 : receive_available_flag);
  wire clr_ovr = wr_status && WDATA[utric_pkg::ST_OVERRUN];
  wire clr_addr = wr_status && WDATA[utric_pkg::ST_ADDR];
  wire clr_wake = wr_status && WDATA[utric_pkg::ST_WAKE];
  wire next_ovr = overrun_evt ? 1'b1 : (clr_ovr ? 1'b0 : overrun_flag);
  wire next_addr = (word_accept && word_is_addr) ? 1'b1 :
                   ((clr_addr || (word_accept && !word_is_addr)) ? 1'b0 : addr_flag);
  wire next_wake = wake_evt ? 1'b1 : (clr_wake ? 1'b0 : wake_flag);

  // Interrupt sources, each gated by its own enable
  wire irq_rx = receive_interrupt_enable && (overrun_flag || receive_available_flag); // RULE14 RULE7
  wire irq_idle = transmit_idle_interrupt_enable && transmitter_idle_flag; // RULE15
  wire irq_empty = transmit_empty_interrupt_enable && transmitter_empty_flag; // RULE16
  wire irq_wake = wake_interrupt_enable && wake_flag; // RULE11
  wire next_irq = irq_rx || irq_idle || irq_empty || irq_wake; // RULE18

  // Status word as seen by software
  wire [7:0] status_word = {rx_hold[utric_pkg::ADDR_BIT_9], INT_REQUEST, wake_flag, addr_flag,
                            transmitter_empty_flag, transmitter_idle_flag,
                            receive_available_flag, overrun_flag};

  // Read data multiplexer; unmapped offsets read as zero
  wire [7:0] next_rdata = !RD ? utric_pkg::READ_ZERO :
                          hit_ctrl2 ? uart_tx_rx_int_control :
                          hit_ctrl1 ? ctrl1 :
                          hit_baud ? baud_divisor_register :
                          hit_status ? status_word :
                          hit_data ? rx_hold[utric_pkg::ADDR_BIT_9 - 1:0] :
                          utric_pkg::READ_ZERO;

  // Next value of the second control register; master disable drops both enables
  wire master_off = wr_ctrl1 ? !WDATA[utric_pkg::C1_MASTER] : !port_master_enable;
  wire [7:0] ctrl2_written = wr_ctrl2 ? WDATA : uart_tx_rx_int_control;
  wire [7:0] next_ctrl2 = master_off ?
    (ctrl2_written & ~((8'h01 << utric_pkg::C2_TXEN) | (8'h01 << utric_pkg::C2_RXEN))) :
    ctrl2_written; // RULE17

  // Control registers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      uart_tx_rx_int_control <= utric_pkg::CTRL2_RESET;
      ctrl1 <= utric_pkg::CTRL1_RESET;
      baud_divisor_register <= utric_pkg::BAUD_RESET;
    end else begin
      uart_tx_rx_int_control <= next_ctrl2;
      if (wr_ctrl1) begin
        ctrl1 <= WDATA;
      end
      if (wr_baud) begin
        baud_divisor_register <= WDATA;
      end
    end
  end

  // Received word buffer and flags; disabling the receiver empties it
  always_ff @(posedge CLOCK) begin
    if (RST || !rx_run) begin
      rx_hold <= utric_pkg::WORD_RESET; // RULE3 RULE17
      receive_available_flag <= 1'b0; // RULE3 RULE17
      overrun_flag <= 1'b0; // RULE3 RULE17
      addr_flag <= 1'b0;
    end else begin
      if (word_accept && !buffer_busy) begin
        rx_hold <= word_masked; // RULE9
      end
      receive_available_flag <= next_avail;
      overrun_flag <= next_ovr;
      addr_flag <= next_addr; // RULE7
    end
  end

  // Receive pin synchroniser, kept running for the wake-up path
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      sync_c <= 1'b1;
      rx_level <= 1'b1;
    end else begin
      sync_a <= SERIAL_IN_PIN;
      sync_b <= sync_a;
      sync_c <= sync_b;
      if (levels_agree) begin
        rx_level <= sync_c;
      end
    end
  end

  // Wake-up request stays until software clears it after restarting the clock
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wake_flag <= 1'b0;
      WAKE_REQUEST <= 1'b0;
    end else begin
      wake_flag <= next_wake; // RULE11 RULE13
      WAKE_REQUEST <= next_wake; // RULE11
    end
  end

  // Pin control and engine run outputs
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      SERIAL_OUT_PIN <= 1'b1;
      SERIAL_OUT_OE <= 1'b0;
      RX_PIN_CONTROLLED <= 1'b0;
      RX_LINE <= 1'b1;
      TX_RUN <= 1'b0;
      RX_RUN <= 1'b0;
      WORD_NINE <= 1'b0;
    end else begin
      SERIAL_OUT_PIN <= tx_run ? TX_LINE : 1'b1; // RULE2
      SERIAL_OUT_OE <= tx_run; // RULE1 RULE2 RULE17
      RX_PIN_CONTROLLED <= rx_run; // RULE3 RULE4 RULE17
      RX_LINE <= rx_run ? rx_level : 1'b1; // RULE4
      TX_RUN <= tx_run; // RULE1
      RX_RUN <= rx_run; // RULE3
      WORD_NINE <= word_length_select; // RULE10
    end
  end

  // Interrupt request and read data
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      INT_REQUEST <= 1'b0;
      RDATA <= utric_pkg::READ_ZERO;
    end else begin
      INT_REQUEST <= next_irq; // RULE18
      RDATA <= next_rdata;
    end
  end

  // Baud generator runs while the port is enabled
  utric_baud u_baud (
    .clk(CLOCK),
    .rst(RST),
    .run(port_master_enable),
    .high_speed(baud_speed_select),
    .divisor(baud_divisor_register),
    .tick(BAUD_TICK)
  );
endmodule

// >>> verification/utric_ctrl_props.sv
// Port checker of the serial port enable and interrupt control block
`timescale 1ns/1ps
module utric_ctrl_props (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic TX_LINE,
  input wire logic PORT_CLOCK_OFF,
  input wire logic SERIAL_OUT_PIN,
  input wire logic SERIAL_OUT_OE,
  input wire logic RX_PIN_CONTROLLED,
  input wire logic RX_LINE,
  input wire logic TX_RUN,
  input wire logic RX_RUN,
  input wire logic WORD_NINE,
  input wire logic BAUD_TICK,
  input wire logic WAKE_REQUEST
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Writes to the two control registers
  wire c2_wr = WR && ADDR == utric_pkg::REG_CTRL2;
  wire c1_wr = WR && ADDR == utric_pkg::REG_CTRL1;
  AST_TX_OFF: assert property (c2_wr && !WDATA[7] |=> ##1 !SERIAL_OUT_OE)
    else $error("transmit pin still driven");
  AST_TX_OE: assert property (SERIAL_OUT_OE == TX_RUN)
    else $error("pin drive and transmitter run differ");
  AST_TX_IDLE: assert property (!TX_RUN |-> SERIAL_OUT_PIN)
    else $error("transmit pin low while stopped");
  // While running, the pin carries the shifter line one cycle later
  AST_TX_PIN: assert property (TX_RUN |-> SERIAL_OUT_PIN == $past(TX_LINE))
    else $error("transmit pin does not follow the shifter line");
  AST_RX_OFF: assert property (c2_wr && !WDATA[6] |=> ##1 !RX_RUN && !RX_PIN_CONTROLLED)
    else $error("receiver still running");
  AST_RX_PIN: assert property (RX_RUN == RX_PIN_CONTROLLED && (RX_RUN || RX_LINE))
    else $error("receive pin ownership wrong");
  AST_MASTER: assert property (c1_wr && !WDATA[7] |=> ##1 !TX_RUN && !RX_RUN)
    else $error("port still active after master off");
  AST_WORD: assert property (c1_wr |=> ##1 WORD_NINE == $past(WDATA[6], 2))
    else $error("word length select wrong");
  AST_TICK: assert property (BAUD_TICK |=> !BAUD_TICK [*8])
    else $error("bit ticks too close");
  AST_WAKE: assert property ($rose(WAKE_REQUEST) |-> $past(PORT_CLOCK_OFF))
    else $error("wake request while clock runs");
  // Main scenarios reached
  COV_TICK: cover property (BAUD_TICK);
  COV_WAKE: cover property ($rose(WAKE_REQUEST));
  COV_STOP: cover property ($fell(TX_RUN));
endmodule
bind utric_ctrl utric_ctrl_props i_utric_ctrl_props (.CLOCK, .RST, .ADDR, .WDATA, .WR, .TX_LINE,
  .PORT_CLOCK_OFF, .SERIAL_OUT_PIN, .SERIAL_OUT_OE, .RX_PIN_CONTROLLED, .RX_LINE,
  .TX_RUN, .RX_RUN, .WORD_NINE, .BAUD_TICK, .WAKE_REQUEST);

// >>> verification/utric_peer.sv
// Remote serial peer with a stand-in for the frame shifters
`timescale 1ns/1ps
module utric_peer (
  input wire logic clk,
  input wire logic tx_run,
  output logic serial_in,
  output logic tx_line,
  output logic tx_idle,
  output logic tx_empty,
  output logic word_valid,
  output logic [8:0] word,
  output logic overrun
);
  // Idle line is high, no word offered
  initial begin
    serial_in = 1'b1;
    tx_line = 1'b1;
    tx_idle = 1'b0;
    tx_empty = 1'b0;
    word_valid = 1'b0;
    word = 9'h000;
    overrun = 1'b0;
  end
  // Shifter output toggles while the transmitter runs
  always @(posedge clk) tx_line <= tx_run ? ~tx_line : 1'b1;
  // One finished word for one cycle, then stale data inverted
  task automatic send(input logic [8:0] w);
    @(posedge clk);
    word <= w;
    word_valid <= 1'b1;
    @(posedge clk);
    word_valid <= 1'b0;
    word <= ~w;
  endtask
  // One overrun event pulse
  task automatic ovr;
    @(posedge clk);
    overrun <= 1'b1;
    @(posedge clk);
    overrun <= 1'b0;
  endtask
  // Start bit style falling edge on the receive line
  task automatic fall;
    @(posedge clk);
    serial_in <= 1'b0;
    repeat (10) @(posedge clk);
    serial_in <= 1'b1;
  endtask
  // Transmitter status levels
  task automatic set_tx(input logic idle, input logic empty);
    @(posedge clk);
    tx_idle <= idle;
    tx_empty <= empty;
  endtask
endmodule

// >>> verification/testbench.sv
// Self-checking testbench of the serial port enable and interrupt control block
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic clk_off = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, v;
  logic ser_in, tx_line, tx_idle, tx_empty, rx_valid, rx_ovr;
  logic [8:0] rx_word;
  logic out_pin, out_oe, rx_ctl, rx_line, tx_run, rx_run, word_nine, tick, wake, irq;
  int n_mismatch = 0;
  int comparisons = 0;
  // Receive cases: control values, word, expected status bits
  localparam logic [7:0] RX_C1 [6] = '{8'h80, 8'h80, 8'h80, 8'hC0, 8'hC0, 8'h80};
  localparam logic [7:0] RX_C2 [6] = '{8'hC4, 8'hD4, 8'hD4, 8'hD4, 8'hD4, 8'hC0};
  localparam logic [8:0] RX_W [6] = '{9'h0A5, 9'h023, 9'h080, 9'h0FF, 9'h180, 9'h0A5};
  localparam logic [7:0] RX_ST [6] = '{8'h42, 8'h00, 8'h52, 8'h00, 8'hD2, 8'h02};
  initial begin
    forever #2 clock = ~clock;
  end
  utric_ctrl i_utric_ctrl (.CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .SERIAL_IN_PIN(ser_in), .PORT_CLOCK_OFF(clk_off),
    .TX_LINE(tx_line), .TX_IDLE_IN(tx_idle), .TX_EMPTY_IN(tx_empty), .RX_WORD_VALID(rx_valid),
    .RX_WORD(rx_word), .RX_OVERRUN_EVT(rx_ovr), .SERIAL_OUT_PIN(out_pin),
    .SERIAL_OUT_OE(out_oe), .RX_PIN_CONTROLLED(rx_ctl), .RX_LINE(rx_line), .TX_RUN(tx_run),
    .RX_RUN(rx_run), .WORD_NINE(word_nine), .BAUD_TICK(tick), .WAKE_REQUEST(wake),
    .INT_REQUEST(irq));
  utric_peer peer (.clk(clock), .tx_run(tx_run), .serial_in(ser_in), .tx_line(tx_line),
    .tx_idle(tx_idle), .tx_empty(tx_empty), .word_valid(rx_valid), .word(rx_word),
    .overrun(rx_ovr));
  // Compare one value and count it
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  // One-cycle register write
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // One-cycle register read, data taken in the following cycle
  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Let register outputs follow a write
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Reset values, unmapped read, enables and master disable
  task automatic t_enable;
    rreg(utric_pkg::REG_CTRL2, v);
    chk("ctrl2 reset", utric_pkg::CTRL2_RESET, v);
    chk("pins at reset", 8'h01, {6'h00, out_oe, out_pin});
    rreg(3'h7, v);
    chk("unmapped read", utric_pkg::READ_ZERO, v);
    wreg(utric_pkg::REG_CTRL1, 8'h80);
    wreg(utric_pkg::REG_CTRL2, 8'hC0);
    settle(2);
    chk("both on", 8'h0F, {4'h0, out_oe, tx_run, rx_run, rx_ctl});
    wreg(utric_pkg::REG_CTRL2, 8'h40);
    settle(2);
    chk("tx off", 8'h13, {3'h0, out_pin, out_oe, tx_run, rx_run, rx_ctl});
    wreg(utric_pkg::REG_CTRL2, 8'h80);
    settle(2);
    chk("rx off", 8'h0C, {3'h0, rx_line, out_oe, tx_run, rx_run, rx_ctl} - 8'h10);
    wreg(utric_pkg::REG_CTRL2, 8'hC0);
    wreg(utric_pkg::REG_CTRL1, 8'h40);
    settle(2);
    chk("master off", 8'h01, {4'h0, out_oe, tx_run, rx_run, word_nine});
    rreg(utric_pkg::REG_CTRL2, v);
    chk("ctrl2 after master off", 8'h00, v);
    $display("test enable done");
  endtask
  // Bit tick period in both speed modes with divisor 1
  task automatic t_baud;
    int n;
    for (int hs = 0; hs < 2; hs++) begin
      wreg(utric_pkg::REG_BAUD, 8'h01);
      wreg(utric_pkg::REG_CTRL1, 8'h00);
      wreg(utric_pkg::REG_CTRL2, hs ? 8'hE0 : 8'hC0);
      wreg(utric_pkg::REG_CTRL1, 8'h80);
      n = 0;
      do begin
        settle(1);
        n++;
      end while (tick !== 1'b1 && n < 600);
      n = 0;
      do begin
        settle(1);
        n++;
      end while (tick !== 1'b1 && n < 600);
      chk("tick period", hs ? 8'h20 : 8'h80, 8'(n));
    end
    $display("test baud done");
  endtask
  // Received words with and without address detect, then overrun
  task automatic t_rx;
    for (int i = 0; i < 6; i++) begin
      wreg(utric_pkg::REG_CTRL1, 8'h00);
      wreg(utric_pkg::REG_CTRL1, RX_C1[i]);
      wreg(utric_pkg::REG_CTRL2, RX_C2[i]);
      peer.send(RX_W[i]);
      settle(4);
      chk("rx irq", 8'(RX_ST[i][6]), 8'(irq));
      rreg(utric_pkg::REG_STATUS, v);
      chk("rx status", RX_ST[i], v & 8'hD2);
      rreg(utric_pkg::REG_DATA, v);
      if (RX_ST[i][1]) chk("rx data", RX_W[i][7:0], v);
    end
    wreg(utric_pkg::REG_CTRL2, 8'hC4);
    peer.ovr();
    settle(4);
    rreg(utric_pkg::REG_STATUS, v);
    chk("overrun", 8'h41, v & 8'h41);
    $display("test receive done");
  endtask
  // Transmitter idle and empty sources against their enables
  task automatic t_tx;
    logic [7:0] c2 [4] = '{8'hC2, 8'hC0, 8'hC1, 8'hC1};
    logic [1:0] st [4] = '{2'b10, 2'b11, 2'b01, 2'b10};
    wreg(utric_pkg::REG_CTRL1, 8'h00);
    wreg(utric_pkg::REG_CTRL1, 8'h80);
    for (int i = 0; i < 4; i++) begin
      peer.set_tx(st[i][1], st[i][0]);
      wreg(utric_pkg::REG_CTRL2, c2[i]);
      settle(4);
      chk("tx irq", (i % 2 == 0) ? 8'h01 : 8'h00, 8'(irq));
    end
    $display("test transmit done");
  endtask
  // Wake-up only with clock off and wake enabled
  task automatic t_wake;
    peer.set_tx(1'b0, 1'b0);
    wreg(utric_pkg::REG_CTRL1, 8'h90);
    wreg(utric_pkg::REG_CTRL2, 8'hC8);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      clk_off <= (i != 1);
      if (i == 2) wreg(utric_pkg::REG_CTRL2, 8'hC0);
      peer.fall();
      settle(8);
      chk("wake", (i == 0) ? 8'h03 : 8'h00, {6'h00, wake, irq});
      @(posedge clock);
      clk_off <= 1'b0;
      wreg(utric_pkg::REG_STATUS, 8'h20);
    end
    $display("test wake done");
  endtask
  // Verdict and end of run
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_enable();
    t_baud();
    t_rx();
    t_tx();
    t_wake();
    end_sim();
  end
  // Watchdog against a hang
  initial begin
    #80000;
    n_mismatch++;
    end_sim();
  end
endmodule
